// *** include/misc_defs.svh ***
// register offsets, field positions and reset values of the status and interrupt block
`ifndef MISC_DEFS_SVH
`define MISC_DEFS_SVH

// ----------------------------------------
// register offsets on the local bus
// ----------------------------------------
`define MISC_OFF_IRQ_STATUS 8'h38
`define MISC_OFF_IRQ_CLEAR 8'h38
`define MISC_OFF_JUMPER_LOW 8'h39
`define MISC_OFF_JUMPER_HIGH 8'h3A
`define MISC_OFF_DRIVE_STATUS 8'h3B
`define MISC_OFF_DRIVE_CONTROL 8'h3B
`define MISC_OFF_AUX_BUFFER 8'h2F
`define MISC_OFF_BUFFER_CONTROL 8'h37
`define MISC_OFF_DISK_CMD_STATUS 8'h27

// ----------------------------------------
// field positions
// ----------------------------------------
`define MISC_BIT_ARM_DISK_PTR 0
`define MISC_BIT_HOST_WIDTH 1
`define MISC_BIT_SYNC_CLOCK 0
`define MISC_BIT_DRIVE_HEAD_SEL 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define MISC_RST_DRIVE_CONTROL 5'h00
`define MISC_RST_HOST_WIDTH 1'b0
`define MISC_RST_SYNC_CLOCK 1'b1
`define MISC_RST_READ_DATA 8'h00

`endif

// *** include/misc_pkg.sv ***
// types shared by the status and interrupt block
package misc_pkg;

  // ----------------------------------------
  // host interface modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_XT,
    MODE_AT,
    MODE_SLAVE
  } misc_host_mode_t;

  // ----------------------------------------
  // interface control write fields
  // ----------------------------------------
  typedef struct packed {
    logic raise_host_irq;
    logic clr_drive_change;
    logic clr_soft_reset;
    logic clr_fifo_error;
    logic clr_host_busy;
    logic clr_host_ptr_ready;
    logic clr_disk_bufreq;
    logic clr_cmd_select_slave;
  } misc_irq_clear_t;

  // ----------------------------------------
  // drive link control fields kept by the block
  // ----------------------------------------
  typedef struct packed {
    logic drive_ctrl_reset;
    logic mcu_buffer_access;
    logic reset_out_disable;
    logic input_polarity;
    logic sector_cmp_disable;
  } misc_drive_ctrl_t;

  // ----------------------------------------
  // interrupt source flags, status bits 6 to 0
  // ----------------------------------------
  typedef struct packed {
    logic drive_change_flag;
    logic soft_reset_flag;
    logic fifo_error_flag;
    logic disk_done_flag;
    logic host_ptr_ready_flag;
    logic disk_bufreq_flag;
    logic cmd_select_slave_flag;
  } misc_flags_t;

endpackage

// *** design/misc_flag.sv ***
// one sticky interrupt flag with set priority and an optional clear hold
module misc_flag (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic set_i,
  input wire logic clr_i,
  input wire logic hold_i,
  output logic flag_o
);

  // ----------------------------------------
  // flag storage
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_i && !hold_i) begin
      flag_o <= 1'b0;
    end
  end

endmodule // misc_flag

// *** design/misc_top.sv ***
// microcontroller interrupt status and drive interface control block
`include "misc_defs.svh"

module misc_top
  import misc_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  // local bus
  input wire logic [7:0] MCU_ADDR_I,
  input wire logic [7:0] MCU_WDATA_I,
  input wire logic MCU_WR_I,
  input wire logic MCU_RD_I,
  output logic [7:0] MCU_RDATA_O,
  // mode and host events
  input wire misc_host_mode_t HOST_MODE_I,
  input wire logic HOST_DRVHEAD_WR_I,
  input wire logic HOST_DRVHEAD_D4_I,
  input wire logic HOST_SOFT_RESET_I,
  input wire logic HOST_CMD_WR_I,
  input wire logic HOST_SELECT_I,
  input wire logic SLAVE_INTRQ_I,
  input wire logic HOST_IRQ_EN_I,
  // buffer manager events
  input wire logic FIFO_OVERRUN_I,
  input wire logic FIFO_UNDERRUN_I,
  input wire logic HOST_CNT_ZERO_I,
  input wire logic FIFO_EMPTY_I,
  input wire logic HOST_PTR_ARMED_I,
  input wire logic HOST_PTR_LOAD_I,
  input wire logic ARM_DISK_PTR_I,
  // disk controller events
  input wire logic DISK_DONE_I,
  input wire logic DISK_BUFREQ_I,
  // configuration jumpers
  input wire logic READ_CFG_I,
  input wire logic [14:0] BUF_ADDR_I,
  // raw drive inputs
  input wire logic INDEX_I,
  input wire logic SECTOR_I,
  input wire logic WRITE_FAULT_I,
  input wire logic DRIVE_READY_I,
  // outputs
  output logic MCU_IRQ_O,
  output logic HOST_IRQ_O,
  output logic CLR_XT_BUSY_O,
  output logic CLR_AT_BUSY_O,
  output logic BOARD_RESET_O,
  output logic DRIVE_CTRL_RESET_O,
  output logic MCU_BUFFER_ACCESS_O,
  output logic SECTOR_CMP_DISABLE_O,
  output logic HOST_WIDTH_SEL_O,
  output logic SYNC_CLOCK_SWITCH_O,
  output logic INDEX_O,
  output logic SECTOR_O
);

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic wr_irq_clear;
  logic wr_drive_ctrl;
  logic wr_aux;
  logic wr_arm_one;
  logic disk_port_access;
  misc_irq_clear_t clr_cmd;

  assign wr_irq_clear = MCU_WR_I && (MCU_ADDR_I == `MISC_OFF_IRQ_CLEAR);
  assign wr_drive_ctrl = MCU_WR_I && (MCU_ADDR_I == `MISC_OFF_DRIVE_CONTROL);
  assign wr_aux = MCU_WR_I && (MCU_ADDR_I == `MISC_OFF_AUX_BUFFER);
  assign wr_arm_one = MCU_WR_I && (MCU_ADDR_I == `MISC_OFF_BUFFER_CONTROL) &&
                      MCU_WDATA_I[`MISC_BIT_ARM_DISK_PTR];
  assign disk_port_access = (MCU_WR_I || MCU_RD_I) && (MCU_ADDR_I == `MISC_OFF_DISK_CMD_STATUS);
  // only bits written as one act; zeros leave everything alone
  assign clr_cmd = wr_irq_clear ? misc_irq_clear_t'(MCU_WDATA_I) : misc_irq_clear_t'(8'h00);

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  logic mode_at;
  logic mode_xt;
  logic mode_slave;

  always_comb begin
    mode_at = 1'b0;
    mode_xt = 1'b0;
    mode_slave = 1'b0;
    unique case (HOST_MODE_I)
      MODE_AT: mode_at = 1'b1;
      MODE_SLAVE: mode_slave = 1'b1;
      MODE_XT: mode_xt = 1'b1;
      default: mode_xt = 1'b1;
    endcase
  end

  // ----------------------------------------
  // host drive/head bit 4 copy
  // ----------------------------------------
  logic drive_head_reg;
  logic drive_change_set;

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      drive_head_reg <= 1'b0;
    end else if (HOST_DRVHEAD_WR_I) begin
      drive_head_reg <= HOST_DRVHEAD_D4_I;
    end
  end

  assign drive_change_set = mode_at && HOST_DRVHEAD_WR_I && (HOST_DRVHEAD_D4_I != drive_head_reg);

  // ----------------------------------------
  // edge detection for level sources
  // ----------------------------------------
  logic slave_intrq_q;
  logic host_ready_cond_q;
  logic host_ready_cond;

  assign host_ready_cond = HOST_CNT_ZERO_I && FIFO_EMPTY_I && !HOST_PTR_ARMED_I;

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      slave_intrq_q <= 1'b0;
      host_ready_cond_q <= 1'b0;
    end else begin
      slave_intrq_q <= SLAVE_INTRQ_I;
      host_ready_cond_q <= host_ready_cond;
    end
  end

  // ----------------------------------------
  // interrupt source flags
  // ----------------------------------------
  misc_flags_t flags;
  logic [6:0] flag_set;
  logic [6:0] flag_clr;
  logic [6:0] flag_hold;
  logic bufreq_hold;

  assign flag_set[6] = drive_change_set;
  assign flag_set[5] = HOST_SOFT_RESET_I;
  assign flag_set[4] = FIFO_OVERRUN_I || FIFO_UNDERRUN_I;
  assign flag_set[3] = DISK_DONE_I;
  assign flag_set[2] = (host_ready_cond && !host_ready_cond_q) || HOST_PTR_LOAD_I;
  assign flag_set[1] = DISK_BUFREQ_I;
  assign flag_set[0] = (mode_at && HOST_CMD_WR_I) || (mode_xt && HOST_SELECT_I) ||
                       (mode_slave && SLAVE_INTRQ_I && !slave_intrq_q);

  assign flag_clr[6] = clr_cmd.clr_drive_change;
  assign flag_clr[5] = clr_cmd.clr_soft_reset;
  assign flag_clr[4] = clr_cmd.clr_fifo_error;
  assign flag_clr[3] = disk_port_access;
  assign flag_clr[2] = clr_cmd.clr_host_ptr_ready;
  assign flag_clr[1] = clr_cmd.clr_disk_bufreq;
  assign flag_clr[0] = clr_cmd.clr_cmd_select_slave;

  assign flag_hold = {5'h00, bufreq_hold, 1'b0};

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_flag
      misc_flag u_flag (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESET_N_I),
        .set_i(flag_set[gi]),
        .clr_i(flag_clr[gi]),
        .hold_i(flag_hold[gi]),
        .flag_o(flags[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // disk request hold until arm bit written
  // ----------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      bufreq_hold <= 1'b0;
    end else if (DISK_BUFREQ_I && !flags.disk_bufreq_flag && !ARM_DISK_PTR_I) begin
      bufreq_hold <= 1'b1;
    end else if (wr_arm_one) begin
      bufreq_hold <= 1'b0;
    end
  end

  // ----------------------------------------
  // microcontroller interrupt
  // ----------------------------------------
  logic irq_summary;

  assign irq_summary = |flags;

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      MCU_IRQ_O <= 1'b0;
    end else begin
      MCU_IRQ_O <= |(flag_set | (flags & ~(flag_clr & ~flag_hold)));
    end
  end

  // ----------------------------------------
  // host interrupt and busy clear pulses
  // ----------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      HOST_IRQ_O <= 1'b0;
      CLR_XT_BUSY_O <= 1'b0;
      CLR_AT_BUSY_O <= 1'b0;
    end else begin
      HOST_IRQ_O <= clr_cmd.raise_host_irq && HOST_IRQ_EN_I;
      CLR_XT_BUSY_O <= clr_cmd.clr_host_busy && !mode_at;
      CLR_AT_BUSY_O <= clr_cmd.clr_host_busy && mode_at;
    end
  end

  // ----------------------------------------
  // drive link control
  // ----------------------------------------
  misc_drive_ctrl_t drive_ctrl;

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      drive_ctrl <= `MISC_RST_DRIVE_CONTROL;
    end else if (wr_drive_ctrl) begin
      drive_ctrl <= {MCU_WDATA_I[7], MCU_WDATA_I[3:0]};
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      DRIVE_CTRL_RESET_O <= 1'b0;
      MCU_BUFFER_ACCESS_O <= 1'b0;
      SECTOR_CMP_DISABLE_O <= 1'b0;
    end else begin
      DRIVE_CTRL_RESET_O <= drive_ctrl.drive_ctrl_reset;
      MCU_BUFFER_ACCESS_O <= drive_ctrl.mcu_buffer_access;
      SECTOR_CMP_DISABLE_O <= drive_ctrl.sector_cmp_disable;
    end
  end

  // ----------------------------------------
  // board reset on host soft reset
  // ----------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      BOARD_RESET_O <= 1'b0;
    end else begin
      BOARD_RESET_O <= HOST_SOFT_RESET_I && !drive_ctrl.reset_out_disable;
    end
  end

  // ----------------------------------------
  // drive input polarity
  // ----------------------------------------
  logic index_act;
  logic sector_act;
  logic write_fault_in;
  logic drive_ready_in;

  assign index_act = INDEX_I ^ !drive_ctrl.input_polarity;
  assign sector_act = SECTOR_I ^ !drive_ctrl.input_polarity;
  assign write_fault_in = WRITE_FAULT_I ^ !drive_ctrl.input_polarity;
  assign drive_ready_in = DRIVE_READY_I ^ !drive_ctrl.input_polarity;

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      INDEX_O <= 1'b0;
      SECTOR_O <= 1'b0;
    end else begin
      INDEX_O <= index_act;
      SECTOR_O <= sector_act;
    end
  end

  // ----------------------------------------
  // auxiliary buffer width and clock switch
  // ----------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      HOST_WIDTH_SEL_O <= `MISC_RST_HOST_WIDTH;
      SYNC_CLOCK_SWITCH_O <= `MISC_RST_SYNC_CLOCK;
    end else if (wr_aux) begin
      HOST_WIDTH_SEL_O <= MCU_WDATA_I[`MISC_BIT_HOST_WIDTH];
      SYNC_CLOCK_SWITCH_O <= MCU_WDATA_I[`MISC_BIT_SYNC_CLOCK];
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = `MISC_RST_READ_DATA;
    unique case (MCU_ADDR_I)
      `MISC_OFF_IRQ_STATUS: next_rdata = {irq_summary, flags};
      `MISC_OFF_JUMPER_LOW: next_rdata = READ_CFG_I ? BUF_ADDR_I[7:0] : 8'h00;
      `MISC_OFF_JUMPER_HIGH: next_rdata = READ_CFG_I ? {1'b0, BUF_ADDR_I[14:8]} : 8'h00;
      `MISC_OFF_DRIVE_STATUS: next_rdata = {drive_ctrl.drive_ctrl_reset, drive_ready_in, write_fault_in,
                                            drive_head_reg, drive_ctrl.mcu_buffer_access,
                                            drive_ctrl.reset_out_disable, drive_ctrl.input_polarity,
                                            drive_ctrl.sector_cmp_disable};
      `MISC_OFF_AUX_BUFFER: next_rdata = {6'h00, HOST_WIDTH_SEL_O, SYNC_CLOCK_SWITCH_O};
      default: next_rdata = `MISC_RST_READ_DATA;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      MCU_RDATA_O <= `MISC_RST_READ_DATA;
    end else if (MCU_RD_I) begin
      MCU_RDATA_O <= next_rdata;
    end
  end

endmodule // misc_top

// *** verif/misc_chk_assertions.sv ***
// port assertions for the status and interrupt block
module misc_chk
  import misc_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic [7:0] MCU_ADDR_I,
  input wire logic [7:0] MCU_WDATA_I,
  input wire logic MCU_WR_I,
  input wire logic MCU_RD_I,
  input wire logic [7:0] MCU_RDATA_O,
  input wire misc_host_mode_t HOST_MODE_I,
  input wire logic HOST_SOFT_RESET_I,
  input wire logic HOST_IRQ_EN_I,
  input wire logic READ_CFG_I,
  input wire logic [14:0] BUF_ADDR_I,
  input wire logic DRIVE_READY_I,
  input wire logic MCU_IRQ_O,
  input wire logic HOST_IRQ_O,
  input wire logic CLR_XT_BUSY_O,
  input wire logic CLR_AT_BUSY_O,
  input wire logic BOARD_RESET_O,
  input wire logic DRIVE_CTRL_RESET_O
);
  logic wr38, set_host, at, ctl7;
  logic [7:0] lo;
  assign wr38 = MCU_WR_I && MCU_ADDR_I == 8'h38;
  assign set_host = wr38 && MCU_WDATA_I[7];
  assign at = HOST_MODE_I == MODE_AT;
  assign ctl7 = MCU_WDATA_I[7];
  assign lo = BUF_ADDR_I[7:0];
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  irq_summary_a: assert property (MCU_RD_I && MCU_ADDR_I == 8'h38 |=> MCU_RDATA_O[7] == $past(MCU_IRQ_O)
    && MCU_RDATA_O[7] == (|MCU_RDATA_O[6:0])) else $error("status bit 7 wrong");
  soft_irq_a: assert property (HOST_SOFT_RESET_I |=> MCU_IRQ_O) else $error("no irq on soft reset");
  board_reset_a: assert property (BOARD_RESET_O |-> $past(HOST_SOFT_RESET_I)) else $error("stray reset");
  host_irq_a: assert property (set_host && HOST_IRQ_EN_I |=> HOST_IRQ_O) else $error("host irq missing");
  host_irq_cause_a: assert property (HOST_IRQ_O |-> $past(set_host)) else $error("stray host irq");
  busy_clear_a: assert property (wr38 && MCU_WDATA_I[3] |=> CLR_AT_BUSY_O == $past(at)
    && CLR_XT_BUSY_O == !$past(at)) else $error("busy clear wrong");
  jumper_low_a: assert property (MCU_RD_I && MCU_ADDR_I == 8'h39 && READ_CFG_I |=> MCU_RDATA_O == $past(lo))
    else $error("jumper low wrong");
  ready_read_a: assert property (MCU_RD_I && MCU_ADDR_I == 8'h3B && $stable(DRIVE_READY_I) |=>
    MCU_RDATA_O[6] == ($past(DRIVE_READY_I) ^ !MCU_RDATA_O[1])) else $error("drive ready wrong");
  drive_reset_a: assert property (MCU_WR_I && MCU_ADDR_I == 8'h3B |=> ##1 DRIVE_CTRL_RESET_O == $past(ctl7, 2))
    else $error("drive reset wrong");
  cover property (HOST_SOFT_RESET_I);
  cover property (HOST_IRQ_O);
  cover property (MCU_RD_I && MCU_ADDR_I == 8'h39 && READ_CFG_I);
endmodule // misc_chk

bind misc_top misc_chk u_chk (.SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .MCU_ADDR_I(MCU_ADDR_I),
  .MCU_WDATA_I(MCU_WDATA_I), .MCU_WR_I(MCU_WR_I), .MCU_RD_I(MCU_RD_I), .MCU_RDATA_O(MCU_RDATA_O),
  .HOST_MODE_I(HOST_MODE_I), .HOST_SOFT_RESET_I(HOST_SOFT_RESET_I), .HOST_IRQ_EN_I(HOST_IRQ_EN_I),
  .READ_CFG_I(READ_CFG_I), .BUF_ADDR_I(BUF_ADDR_I), .DRIVE_READY_I(DRIVE_READY_I), .MCU_IRQ_O(MCU_IRQ_O),
  .HOST_IRQ_O(HOST_IRQ_O), .CLR_XT_BUSY_O(CLR_XT_BUSY_O), .CLR_AT_BUSY_O(CLR_AT_BUSY_O),
  .BOARD_RESET_O(BOARD_RESET_O), .DRIVE_CTRL_RESET_O(DRIVE_CTRL_RESET_O));

// *** verif/misc_mcu_model.sv ***
// microcontroller model driving the local register bus
module misc_mcu_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // released lines show the inverse so stale values never look valid
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
endmodule // misc_mcu_model

// *** verif/misc_top_test.sv ***
// self-checking bench for the status and interrupt block
module misc_top_test
  import misc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, cfg, d4, en, arm, rdy, wflt, idx, sct;
  logic [10:0] ev;
  logic [14:0] ba;
  misc_host_mode_t mode;
  logic [7:0] addr, wdata, rdata, v, d;
  logic wr, rd, irq, hirq, cxt, cat, brst, drst, mba, scd, hws, scs, idx_o, sct_o;
  logic [31:0] seed;
  int n_fail, total_checks, exp_flags, k;
  int kt[14] = '{0, 0, 1, 1, 2, 3, 4, 4, 5, 9, 6, 6, 7, 8};
  misc_top u_dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .MCU_ADDR_I(addr), .MCU_WDATA_I(wdata),
    .MCU_WR_I(wr), .MCU_RD_I(rd), .MCU_RDATA_O(rdata), .HOST_MODE_I(mode), .HOST_DRVHEAD_WR_I(ev[0]),
    .HOST_DRVHEAD_D4_I(d4), .HOST_SOFT_RESET_I(ev[1]), .HOST_CMD_WR_I(ev[7]), .HOST_SELECT_I(ev[8]),
    .SLAVE_INTRQ_I(ev[10]), .HOST_IRQ_EN_I(en), .FIFO_OVERRUN_I(ev[2]), .FIFO_UNDERRUN_I(ev[3]),
    .HOST_CNT_ZERO_I(ev[9]), .FIFO_EMPTY_I(ev[9]), .HOST_PTR_ARMED_I(1'b0), .HOST_PTR_LOAD_I(ev[5]),
    .ARM_DISK_PTR_I(arm), .DISK_DONE_I(ev[4]), .DISK_BUFREQ_I(ev[6]), .READ_CFG_I(cfg), .BUF_ADDR_I(ba),
    .INDEX_I(idx), .SECTOR_I(sct), .WRITE_FAULT_I(wflt), .DRIVE_READY_I(rdy), .MCU_IRQ_O(irq),
    .HOST_IRQ_O(hirq), .CLR_XT_BUSY_O(cxt), .CLR_AT_BUSY_O(cat), .BOARD_RESET_O(brst),
    .DRIVE_CTRL_RESET_O(drst), .MCU_BUFFER_ACCESS_O(mba), .SECTOR_CMP_DISABLE_O(scd),
    .HOST_WIDTH_SEL_O(hws), .SYNC_CLOCK_SWITCH_O(scs), .INDEX_O(idx_o), .SECTOR_O(sct_o));
  misc_mcu_model u_mcu (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    u_mcu.rd_reg(a, q);
    chk(q, e);
  endtask
  task automatic pulse(input int n);
    @(negedge clk);
    ev = 11'h001 << n;
    @(negedge clk);
    ev = 11'h000;
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #500000;
    n_fail++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    ev = 11'h000;
    mode = MODE_AT;
    {d4, en, arm, cfg, idx, sct, rdy, wflt} = 8'h38;
    ba = 15'h0000;
    seed = 32'h05A5;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    chk({6'h00, drst, scs}, 8'h01);
    u_mcu.wr_reg(8'h2F, 8'h02);
    rd_chk(8'h2F, 8'h02);
    chk({6'h00, hws, scs}, 8'h02);
    // ----------------------------------------
    // each source but the slave interrupt sets, survives a zero write, clears
    // ----------------------------------------
    for (int j = 0; j < 2; j++) begin
      for (int i = 6; i >= 0; i--) begin
        k = kt[(6 - i) * 2 + j];
        mode = (k == 8) ? MODE_XT : MODE_AT;
        if (k == 0) d4 = ~d4;
        pulse(k);
        exp_flags = 1 << i;
        chk({6'h00, brst, irq}, (k == 1) ? 8'h03 : 8'h01);
        rd_chk(8'h38, 8'h80 | 8'(exp_flags));
        u_mcu.wr_reg(8'h38, 8'h00);
        rd_chk(8'h38, 8'h80 | 8'(exp_flags));
        if (i == 3) u_mcu.rd_reg(8'h27, d);
        else u_mcu.wr_reg(8'h38, 8'(exp_flags));
        rd_chk(8'h38, 8'h00);
      end
    end
    arm = 1'b0;
    pulse(6);
    u_mcu.wr_reg(8'h38, 8'h02);
    rd_chk(8'h38, 8'h82);
    u_mcu.wr_reg(8'h37, 8'h01);
    u_mcu.wr_reg(8'h38, 8'h02);
    rd_chk(8'h38, 8'h00);
    arm = 1'b1;
    mode = MODE_SLAVE;
    pulse(10);
    rd_chk(8'h38, 8'h81);
    u_mcu.wr_reg(8'h38, 8'h01);
    rd_chk(8'h38, 8'h00);
    for (int m = 0; m < 2; m++) begin
      mode = m ? MODE_XT : MODE_AT;
      en = (m == 0);
      u_mcu.wr_reg(8'h38, 8'h88);
      chk({5'h00, hirq, cat, cxt}, m ? 8'h01 : 8'h06);
    end
    seed = lfsr(seed);
    ba = seed[14:0];
    cfg = 1'b1;
    repeat (5000) @(negedge clk);
    rd_chk(8'h39, ba[7:0]);
    rd_chk(8'h3A, {1'b0, ba[14:8]});
    cfg = 1'b0;
    rd_chk(8'h50, 8'h00);
    for (int n = 0; n < 6; n++) begin
      seed = lfsr(seed);
      v = seed[7:0] & 8'h8F;
      {rdy, wflt, idx, sct} = seed[11:8];
      u_mcu.wr_reg(8'h3B, v);
      rd_chk(8'h3B, {v[7], rdy ^ ~v[1], wflt ^ ~v[1], d4, v[3:0]});
      chk({3'h0, drst, mba, scd, idx_o, sct_o}, {3'h0, v[7], v[3], v[0], idx ^ ~v[1], sct ^ ~v[1]});
    end
    u_mcu.wr_reg(8'h3B, 8'h84);
    pulse(1);
    chk({6'h00, brst, irq}, 8'h01);
    u_mcu.wr_reg(8'h38, 8'h20);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    chk({6'h00, drst, irq}, 8'h00);
    test_done();
  end
endmodule // misc_top_test
